// ===== hdl/uesc_pkg.sv
package uesc_pkg;

    // --------------------
    // register byte offsets
    // --------------------
    localparam logic [7:0] OFS_ERR_FLAGS = 8'h00;
    localparam logic [7:0] OFS_ERR_ENABLE = 8'h04;
    localparam logic [7:0] OFS_XFER_STATUS = 8'h08;
    localparam logic [7:0] OFS_LINK_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_FUNC_ADDRESS = 8'h10;
    localparam logic [7:0] OFS_FRAME_LOW = 8'h14;
    localparam logic [7:0] OFS_IRQ_CONTROL = 8'h18;
    localparam logic [7:0] OFS_TOKEN_DONE = 8'h1C;

    // --------------------
    // error flag and mask positions
    // --------------------
    localparam int ERR_STUFF = 7;
    localparam int ERR_BUS_MATRIX = 6;
    localparam int ERR_MEMORY = 5;
    localparam int ERR_TURNAROUND = 4;
    localparam int ERR_DATA_FIELD = 3;
    localparam int ERR_DATA_CRC = 2;
    localparam int ERR_TOKEN_CRC_OR_EOF = 1;
    localparam int ERR_PID = 0;

    // --------------------
    // control, address, interrupt, token done and status bit positions
    // --------------------
    localparam int CON_LIVE_J = 7;
    localparam int CON_LIVE_SE0 = 6;
    localparam int CON_PKT_DISABLE = 5;
    localparam int CON_BUS_RESET = 4;
    localparam int CON_HOST_EN = 3;
    localparam int CON_RESUME = 2;
    localparam int CON_PP_RESET = 1;
    localparam int CON_ENABLE = 0;
    localparam int ADDR_LOW_SPEED = 7;
    localparam int IRQ_ERROR_EN = 1;
    localparam int TOKEN_DONE_BIT = 3;
    localparam int STAT_EP_LSB = 4;
    localparam int STAT_DIR = 3;
    localparam int STAT_ODD = 2;

    // --------------------
    // reset values
    // --------------------
    localparam logic [7:0] RST_BYTE = 8'h00;

    // --------------------
    // status queue shape
    // --------------------
    localparam int STATUS_DEPTH = 4;
    localparam int STATUS_WIDTH = 6;

    // --------------------
    // timing
    // --------------------
    localparam int CLK_PERIOD_PS = 20000;
    localparam int FS_BIT_PS = 83333;
    localparam int FS_BIT_CYCLES = (FS_BIT_PS / CLK_PERIOD_PS < 1) ? 1 : FS_BIT_PS / CLK_PERIOD_PS;
    localparam int TURNAROUND_BIT_TIMES = 16;
    localparam int FRAME_PERIOD_US = 1000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_US * 1000000 / CLK_PERIOD_PS;

endpackage

// ===== hdl/uesc_status_fifo.sv
`timescale 1ns/100ps
module uesc_status_fifo #(
    parameter int WIDTH = uesc_pkg::STATUS_WIDTH,
    parameter int DEPTH = uesc_pkg::STATUS_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // drain side
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic valid,
    output logic full
);
    import uesc_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } uesc_fifo_state_t;

    uesc_fifo_state_t st;
    uesc_fifo_state_t next_st;
    logic do_push;
    logic do_pop;
    logic [PW-1:0] wr_idx;

    assign valid = (st.count != '0);
    assign full = (st.count == CW'(DEPTH));
    assign head = st.mem[st.rd_ptr];

    // --------------------
    // queue update
    // --------------------
    // depth is taken as a power of two so the pointers wrap by width
    always_comb
    begin
        next_st = st;
        do_pop = pop && valid;
        // a completion arriving while full is dropped, unless a pop frees a slot
        do_push = push && (!full || do_pop);
        wr_idx = PW'(st.rd_ptr + st.count);
        if (do_pop)
        begin
            next_st.rd_ptr = PW'(st.rd_ptr + 1'b1);
        end
        if (do_push)
        begin
            next_st.mem[wr_idx] = push_data;
        end
        next_st.count = CW'(st.count + CW'(do_push) - CW'(do_pop));
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule

// ===== hdl/uesc_top.sv
`timescale 1ns/100ps
// Overview of operation
// (RULE1) data CRC16 reject sets data CRC flag; software writes one to clear.
// (RULE2) device mode: token CRC5 reject sets the token CRC flag at bit 1.
// (RULE3) host mode: bit 1 flags end-of-frame error, busy at countdown zero.
// (RULE4) failed PID complement check sets the PID flag, never set otherwise.
// (RULE5) late bus grant or truncated receive sets the memory access flag.
// (RULE6) over sixteen idle bit times after EOP without reply flags time-out.
// (RULE7) error enable mask bits 7..0 gate matching flags to error interrupt.
// (RULE8) unmasked error reaches module interrupt only with error irq enable.
// (RULE9) status register shows head of a four-entry completed transfer queue.
// (RULE10) status valid only with token done set; clearing it pops queue.
// (RULE11) status bits 7..4 hold endpoint number of the transfer.
// (RULE12) status bit 3 transmit/receive, bit 2 odd/even descriptor bank.
// (RULE13) control bits 7 and 6 show live J state and SE0, read-only.
// (RULE14) device mode: bit 5 disables packets, set on setup token.
// (RULE15) host mode: bit 5 shows token busy; software waits before next.
// (RULE16) host mode: bus reset driven while bit 4 is one.
// (RULE17) bit 3 enables host; each change resets all host logic.
// (RULE18) software holds resume 10 ms as function, 25 ms as host.
// (RULE19) resume bit drives resume; host appends low-speed EOP on clear.
// (RULE20) writing one to ping-pong reset returns pointers to even bank.
// (RULE21) bit 0: device module enable, host frame-start every 1 ms.
// (RULE22) address bits 6..0 device address, bit 7 low-speed next token.
// (RULE23) frame number low bits load on each received frame-start token.
// (RULE24) shared bits take meaning from the current host enable setting.
module uesc_top #(
    parameter int FRAME_TICKS = uesc_pkg::FRAME_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // bus line levels from pins
    input wire logic LINE_J,
    input wire logic LINE_SE0,
    // error events from the packet engine
    input wire logic STUFF_ERR,
    input wire logic BUS_MATRIX_ERR,
    input wire logic GRANT_LATE,
    input wire logic RX_TRUNCATED,
    input wire logic DATA_FIELD_ERR,
    input wire logic DATA_CRC_ERR,
    input wire logic TOKEN_CRC_ERR,
    input wire logic PID_ERR,
    // engine activity
    input wire logic LINK_ACTIVE,
    input wire logic SOF_COUNT_ZERO,
    input wire logic EOP_DONE,
    input wire logic RESPONSE_START,
    input wire logic TOKEN_BUSY,
    input wire logic SETUP_RCVD,
    input wire logic SOF_RCVD,
    input wire logic [10:0] FRAME_NUMBER,
    // completed transfers
    input wire logic XFER_DONE,
    input wire logic [3:0] XFER_EP,
    input wire logic XFER_TX,
    input wire logic XFER_ODD,
    // control outputs
    output logic MODULE_ENABLE,
    output logic FRAME_START_ENABLE,
    output logic SOF_SEND,
    output logic PACKET_DISABLE,
    output logic BUS_RESET_DRIVE,
    output logic RESUME_DRIVE,
    output logic LS_EOP_APPEND,
    output logic HOST_LOGIC_RESET,
    output logic PINGPONG_RESET,
    output logic [6:0] FUNC_ADDRESS,
    output logic LOW_SPEED_NEXT,
    output logic MODULE_IRQ
);
    import uesc_pkg::*;

    typedef struct packed {
        logic [7:0] err_flags;
        logic [7:0] err_enable;
        logic [7:0] func_addr;
        logic [7:0] frame_low;
        logic pkt_disable;
        logic bus_reset;
        logic host_en;
        logic resume;
        logic pp_reset;
        logic mod_en;
        logic err_irq_en;
        logic [2:0] sync_j;
        logic [2:0] sync_se0;
        logic live_j;
        logic live_se0;
        logic [31:0] rdata;
        logic slverr;
        logic wait_resp;
        logic [4:0] idle_bits;
        logic [2:0] bit_div;
        logic [15:0] frame_timer;
        logic sof_pulse;
        logic ls_eop;
        logic host_rst;
        logic pp_pulse;
    } uesc_state_t;

    uesc_state_t st;
    uesc_state_t next_st;

    logic setup_phase;
    logic wr_access;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic [7:0] con_read;
    logic [31:0] rd_value;
    logic bit_tick;
    logic timeout_evt;
    logic pop_req;
    logic [STATUS_WIDTH-1:0] fifo_head;
    logic fifo_valid;

    // --------------------
    // bus decode
    // --------------------
    assign setup_phase = PSEL && !PENABLE;
    // all fields sit in the low byte, so only lane 0 carries a write
    assign wr_access = PSEL && PENABLE && PWRITE && PSTRB[0] && !st.slverr;
    assign wbyte = PWDATA[7:0];
    assign mapped = (PADDR == OFS_ERR_FLAGS) || (PADDR == OFS_ERR_ENABLE) ||
                    (PADDR == OFS_XFER_STATUS) || (PADDR == OFS_LINK_CONTROL) ||
                    (PADDR == OFS_FUNC_ADDRESS) || (PADDR == OFS_FRAME_LOW) ||
                    (PADDR == OFS_IRQ_CONTROL) || (PADDR == OFS_TOKEN_DONE);
    // (RULE10) pop on clear
    assign pop_req = wr_access && (PADDR == OFS_TOKEN_DONE) && wbyte[TOKEN_DONE_BIT];

    // --------------------
    // transfer status queue
    // --------------------
    // (RULE9) four-entry queue
    uesc_status_fifo #(
        .WIDTH(STATUS_WIDTH),
        .DEPTH(STATUS_DEPTH)
    ) u_status_fifo (
        .clock(CLOCK),
        .nrst(NRST),
        .push(XFER_DONE),
        .push_data({XFER_EP, XFER_TX, XFER_ODD}),
        .pop(pop_req),
        .head(fifo_head),
        .valid(fifo_valid),
        .full()
    );

    // --------------------
    // read view
    // --------------------
    always_comb
    begin
        con_read = RST_BYTE;
        // (RULE13) live line flags
        con_read[CON_LIVE_J] = st.live_j;
        con_read[CON_LIVE_SE0] = st.live_se0;
        // (RULE24) bit 5 by role
        con_read[CON_PKT_DISABLE] = st.host_en ? TOKEN_BUSY : st.pkt_disable;
        con_read[CON_BUS_RESET] = st.bus_reset;
        con_read[CON_HOST_EN] = st.host_en;
        con_read[CON_RESUME] = st.resume;
        con_read[CON_PP_RESET] = st.pp_reset;
        con_read[CON_ENABLE] = st.mod_en;
        rd_value = '0;
        case (PADDR)
            OFS_ERR_FLAGS: rd_value[7:0] = st.err_flags;
            OFS_ERR_ENABLE: rd_value[7:0] = st.err_enable;
            // (RULE11) (RULE12) head entry, zero while empty
            OFS_XFER_STATUS: rd_value[7:0] = fifo_valid ? {fifo_head, 2'b00} : RST_BYTE;
            OFS_LINK_CONTROL: rd_value[7:0] = con_read;
            OFS_FUNC_ADDRESS: rd_value[7:0] = st.func_addr;
            OFS_FRAME_LOW: rd_value[7:0] = st.frame_low;
            OFS_IRQ_CONTROL: rd_value[IRQ_ERROR_EN] = st.err_irq_en;
            OFS_TOKEN_DONE: rd_value[TOKEN_DONE_BIT] = fifo_valid;
            default: rd_value = '0;
        endcase
    end

    // --------------------
    // error events
    // --------------------
    assign bit_tick = (st.bit_div == 3'(FS_BIT_CYCLES - 1));
    // (RULE6) more than sixteen bit times
    assign timeout_evt = st.wait_resp && bit_tick && !RESPONSE_START &&
                         (st.idle_bits == 5'(TURNAROUND_BIT_TIMES));

    always_comb
    begin
        err_set = '0;
        err_set[ERR_STUFF] = STUFF_ERR;
        err_set[ERR_BUS_MATRIX] = BUS_MATRIX_ERR;
        // (RULE5) grant late or truncation
        err_set[ERR_MEMORY] = GRANT_LATE || RX_TRUNCATED;
        err_set[ERR_TURNAROUND] = timeout_evt;
        err_set[ERR_DATA_FIELD] = DATA_FIELD_ERR;
        // (RULE1) data CRC reject
        err_set[ERR_DATA_CRC] = DATA_CRC_ERR;
        // (RULE2) (RULE3) shared bit by role
        err_set[ERR_TOKEN_CRC_OR_EOF] = st.host_en ? (LINK_ACTIVE && SOF_COUNT_ZERO) : TOKEN_CRC_ERR;
        // (RULE4) PID check failure
        err_set[ERR_PID] = PID_ERR;
        err_clr = (wr_access && (PADDR == OFS_ERR_FLAGS)) ? wbyte : RST_BYTE;
    end

    // --------------------
    // next state
    // --------------------
    always_comb
    begin
        next_st = st;
        next_st.sof_pulse = 1'b0;
        next_st.ls_eop = 1'b0;
        next_st.host_rst = 1'b0;
        next_st.pp_pulse = 1'b0;

        // read data and error answer are caught in the setup cycle
        if (setup_phase)
        begin
            next_st.rdata = rd_value;
            next_st.slverr = !mapped;
        end

        // line level synchronisers, change taken once stages two and three agree
        next_st.sync_j = {st.sync_j[1:0], LINE_J};
        next_st.sync_se0 = {st.sync_se0[1:0], LINE_SE0};
        if (st.sync_j[1] == st.sync_j[2])
        begin
            next_st.live_j = st.sync_j[2];
        end
        if (st.sync_se0[1] == st.sync_se0[2])
        begin
            next_st.live_se0 = st.sync_se0[2];
        end

        // sticky flags, an event in the clear cycle wins
        for (int i = 0; i < 8; i++)
        begin
            next_st.err_flags[i] = err_set[i] || (st.err_flags[i] && !err_clr[i]);
        end

        // full-speed bit time divider and turnaround watch
        next_st.bit_div = bit_tick ? 3'h0 : 3'(st.bit_div + 1'b1);
        if (EOP_DONE)
        begin
            next_st.wait_resp = 1'b1;
            next_st.idle_bits = 5'h00;
        end
        else if (RESPONSE_START || timeout_evt)
        begin
            next_st.wait_resp = 1'b0;
        end
        else if (st.wait_resp && bit_tick)
        begin
            next_st.idle_bits = 5'(st.idle_bits + 1'b1);
        end

        if (wr_access)
        begin
            case (PADDR)
                // (RULE7) per-flag mask
                OFS_ERR_ENABLE: next_st.err_enable = wbyte;
                OFS_LINK_CONTROL:
                begin
                    next_st.pkt_disable = wbyte[CON_PKT_DISABLE];
                    // (RULE16) bus reset bit
                    next_st.bus_reset = wbyte[CON_BUS_RESET];
                    next_st.host_en = wbyte[CON_HOST_EN];
                    // (RULE19) resume bit
                    next_st.resume = wbyte[CON_RESUME];
                    next_st.pp_reset = wbyte[CON_PP_RESET];
                    // (RULE20) pointer reset pulse
                    next_st.pp_pulse = wbyte[CON_PP_RESET];
                    next_st.mod_en = wbyte[CON_ENABLE];
                    // (RULE19) low-speed EOP on resume clear
                    next_st.ls_eop = st.host_en && st.resume && !wbyte[CON_RESUME];
                    // (RULE17) host logic reset on change
                    next_st.host_rst = (wbyte[CON_HOST_EN] != st.host_en);
                end
                // (RULE22) address and speed
                OFS_FUNC_ADDRESS: next_st.func_addr = wbyte;
                OFS_FRAME_LOW: next_st.frame_low = wbyte;
                // (RULE8) error interrupt enable
                OFS_IRQ_CONTROL: next_st.err_irq_en = wbyte[IRQ_ERROR_EN];
                default: next_st.func_addr = st.func_addr;
            endcase
        end

        // (RULE14) setup token sets disable
        if (SETUP_RCVD && !st.host_en)
        begin
            next_st.pkt_disable = 1'b1;
        end

        // (RULE23) frame number capture
        if (SOF_RCVD)
        begin
            next_st.frame_low = FRAME_NUMBER[7:0];
        end

        // (RULE21) frame-start every 1 ms in host mode
        next_st.frame_timer = 16'h0000;
        if (st.host_en && st.mod_en && !st.host_rst)
        begin
            if (st.frame_timer == 16'(FRAME_TICKS - 1))
                next_st.sof_pulse = 1'b1;
            else
                next_st.frame_timer = 16'(st.frame_timer + 1'b1);
        end

        // (RULE17) host side state cleared on role change
        if (next_st.host_rst)
        begin
            next_st.frame_timer = 16'h0000;
            next_st.ls_eop = 1'b0;
            next_st.wait_resp = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // --------------------
    // outputs
    // --------------------
    assign PREADY = 1'b1;
    assign PRDATA = st.rdata;
    assign PSLVERR = PSEL && PENABLE && st.slverr;
    // (RULE24) role split of bit 0 and bit 5
    assign MODULE_ENABLE = st.mod_en && !st.host_en;
    assign FRAME_START_ENABLE = st.mod_en && st.host_en;
    assign PACKET_DISABLE = st.pkt_disable && !st.host_en;
    assign SOF_SEND = st.sof_pulse;
    // (RULE16) reset signalling in host mode only
    assign BUS_RESET_DRIVE = st.bus_reset && st.host_en;
    // (RULE19) resume signalling follows the bit
    assign RESUME_DRIVE = st.resume;
    assign LS_EOP_APPEND = st.ls_eop;
    assign HOST_LOGIC_RESET = st.host_rst;
    assign PINGPONG_RESET = st.pp_pulse;
    assign FUNC_ADDRESS = st.func_addr[6:0];
    assign LOW_SPEED_NEXT = st.func_addr[ADDR_LOW_SPEED];
    // (RULE7) (RULE8) masked flags gated by the error interrupt enable
    assign MODULE_IRQ = (|(st.err_flags & st.err_enable)) && st.err_irq_en;

endmodule

// ===== tb/uesc_peer_model.sv
`timescale 1ns/100ps
module uesc_peer_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // request from the bench
    input wire logic kick,
    input wire logic [7:0] reply_delay,
    // toward the packet engine inputs
    output logic eop_done,
    output logic response_start
);
    logic [7:0] wait_cnt;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            eop_done <= 1'b0;
            response_start <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else
        begin
            eop_done <= kick;
            response_start <= wait_cnt == 8'h01;
            if (kick)
                wait_cnt <= reply_delay;
            else if (wait_cnt != 8'h00)
                wait_cnt <= wait_cnt - 8'h01;
        end
    end
endmodule

// ===== tb/uesc_top_props.sv
`timescale 1ns/100ps
module uesc_top_props #(
    parameter int FRAME_TICKS = 50000
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    // control outputs
    input wire logic MODULE_ENABLE,
    input wire logic FRAME_START_ENABLE,
    input wire logic SOF_SEND,
    input wire logic BUS_RESET_DRIVE,
    input wire logic RESUME_DRIVE,
    input wire logic LS_EOP_APPEND,
    input wire logic HOST_LOGIC_RESET,
    input wire logic PINGPONG_RESET,
    input wire logic [6:0] FUNC_ADDRESS,
    input wire logic LOW_SPEED_NEXT,
    input wire logic MODULE_IRQ
);
    import uesc_pkg::*;
    logic wr, ctl_wr, adr_wr;
    logic [31:0] gap;
    assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
    assign ctl_wr = wr && PADDR == OFS_LINK_CONTROL;
    assign adr_wr = wr && PADDR == OFS_FUNC_ADDRESS;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // --------------------
    // cycles since the last frame start
    // --------------------
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            gap <= '0;
        else if (SOF_SEND || !FRAME_START_ENABLE)
            gap <= '0;
        else
            gap <= gap + 32'h1;
    end
    a_addr_load: assert property (adr_wr |=> {LOW_SPEED_NEXT, FUNC_ADDRESS} == $past(PWDATA[7:0]))
        else $error("address not loaded");
    a_resume_follow: assert property (ctl_wr |=> RESUME_DRIVE == $past(PWDATA[CON_RESUME]))
        else $error("resume not following write");
    a_eop_append: assert property (LS_EOP_APPEND |-> $past(ctl_wr) && $past(RESUME_DRIVE) && !RESUME_DRIVE
        ##1 !LS_EOP_APPEND)
        else $error("stray low speed eop");
    a_bus_reset: assert property (ctl_wr && PWDATA[CON_HOST_EN] |=> BUS_RESET_DRIVE == $past(PWDATA[CON_BUS_RESET]))
        else $error("bus reset drive wrong");
    a_host_reset: assert property (HOST_LOGIC_RESET |-> $past(ctl_wr))
        else $error("stray host logic reset");
    a_pp_reset: assert property (ctl_wr && PWDATA[CON_PP_RESET] |=> PINGPONG_RESET)
        else $error("pointer reset missing");
    a_mode_split: assert property (ctl_wr |=> MODULE_ENABLE == ($past(PWDATA[CON_ENABLE]) && !$past(PWDATA[CON_HOST_EN])))
        else $error("role split wrong");
    a_frame_gap: assert property (gap < FRAME_TICKS + 2)
        else $error("frame start overdue");
    a_irq_hold: assert property (MODULE_IRQ && !(PSEL && PENABLE && PWRITE) |=> MODULE_IRQ)
        else $error("interrupt dropped");
    c_sof: cover property (SOF_SEND);
    c_irq: cover property ($rose(MODULE_IRQ));
    c_eop: cover property (LS_EOP_APPEND);
endmodule
bind uesc_top uesc_top_props #(.FRAME_TICKS(FRAME_TICKS)) i_props (.CLOCK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PSTRB, .MODULE_ENABLE, .FRAME_START_ENABLE, .SOF_SEND, .BUS_RESET_DRIVE, .RESUME_DRIVE, .LS_EOP_APPEND,
    .HOST_LOGIC_RESET, .PINGPONG_RESET, .FUNC_ADDRESS, .LOW_SPEED_NEXT, .MODULE_IRQ);

// ===== tb/usb_otg_error_status_control_bench.sv
`timescale 1ns/100ps
module usb_otg_error_status_control_bench;
    import uesc_pkg::*;
    localparam int TICKS = 20;
    logic CLOCK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, LINE_J, LINE_SE0, TOKEN_BUSY, XFER_TX, XFER_ODD;
    logic MODULE_ENABLE, FRAME_START_ENABLE, SOF_SEND, PACKET_DISABLE, BUS_RESET_DRIVE, RESUME_DRIVE, kick, eop;
    logic LS_EOP_APPEND, HOST_LOGIC_RESET, PINGPONG_RESET, LOW_SPEED_NEXT, MODULE_IRQ, resp;
    logic [7:0] PADDR, dly, lfsr;
    logic [31:0] PWDATA, PRDATA, exp_v;
    logic [3:0] PSTRB, XFER_EP;
    logic [10:0] FRAME_NUMBER;
    logic [12:0] evs;
    logic [6:0] FUNC_ADDRESS;
    logic [5:0] sq [5];
    logic [7:0] rt [2] = '{8'h3C, 8'h5A};
    logic [31:0] expq [$];
    int error_cnt, total_checks, n;
    uesc_top #(.FRAME_TICKS(TICKS)) i_dut (.CLOCK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
        .PREADY, .PSLVERR, .LINE_J, .LINE_SE0, .PID_ERR(evs[0]), .TOKEN_CRC_ERR(evs[1]), .DATA_CRC_ERR(evs[2]),
        .DATA_FIELD_ERR(evs[3]), .RX_TRUNCATED(evs[4]), .GRANT_LATE(evs[5]), .BUS_MATRIX_ERR(evs[6]),
        .STUFF_ERR(evs[7]), .SETUP_RCVD(evs[8]), .SOF_RCVD(evs[9]), .LINK_ACTIVE(evs[10]),
        .SOF_COUNT_ZERO(evs[11]), .XFER_DONE(evs[12]), .EOP_DONE(eop), .RESPONSE_START(resp), .TOKEN_BUSY,
        .FRAME_NUMBER, .XFER_EP, .XFER_TX, .XFER_ODD, .MODULE_ENABLE, .FRAME_START_ENABLE, .SOF_SEND,
        .PACKET_DISABLE, .BUS_RESET_DRIVE, .RESUME_DRIVE, .LS_EOP_APPEND, .HOST_LOGIC_RESET, .PINGPONG_RESET,
        .FUNC_ADDRESS, .LOW_SPEED_NEXT, .MODULE_IRQ);
    uesc_peer_model i_peer (.clock(CLOCK), .nrst(NRST), .kick, .reply_delay(dly), .eop_done(eop),
        .response_start(resp));
    initial
    begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end
    // --------------------
    // helpers
    // --------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        k = 0;
        do
        begin
            @(posedge CLOCK);
            k++;
        end
        while (PREADY !== 1'b1 && k < 50);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (k >= 50)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input logic [12:0] v);
        @(posedge CLOCK);
        evs <= v;
        @(posedge CLOCK);
        evs <= '0;
    endtask
    // read results land here, oldest note first
    always @(posedge CLOCK)
        if (PSEL && PENABLE && PREADY)
        begin
            cmp(32'(PSLVERR), 32'(PADDR > OFS_TOKEN_DONE));
            if (!PWRITE)
                cmp(PRDATA, expq.pop_front());
        end
    // --------------------
    // main sequence
    // --------------------
    initial
    begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, LINE_J, LINE_SE0, TOKEN_BUSY, evs, kick, dly} = '0;
        {FRAME_NUMBER, XFER_EP, XFER_TX, XFER_ODD, error_cnt, total_checks} = '0;
        PSTRB = 4'hF;
        NRST = 1'b0;
        lfsr = 8'h09;
        repeat (10) @(posedge CLOCK);
        NRST <= 1'b1;
        for (int a = 0; a <= 8'h20; a += 4)
            rd(8'(a), 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            exp_v = (i == 4) ? 32'h20 : 32'h1 << i;
            pulse(13'h1 << i);
            rd(OFS_ERR_FLAGS, exp_v);
            apb(1'b1, OFS_ERR_FLAGS, exp_v);
            rd(OFS_ERR_FLAGS, 32'h0);
        end
        apb(1'b1, OFS_ERR_ENABLE, 32'h04);
        apb(1'b1, OFS_IRQ_CONTROL, 32'h02);
        pulse(13'h001);
        #1 cmp(32'(MODULE_IRQ), 32'h0);
        pulse(13'h004);
        #1 cmp(32'(MODULE_IRQ), 32'h1);
        apb(1'b1, OFS_IRQ_CONTROL, 32'h0);
        #1 cmp(32'(MODULE_IRQ), 32'h0);
        apb(1'b1, OFS_ERR_FLAGS, 32'h05);
        foreach (rt[i])
        begin
            @(posedge CLOCK);
            kick <= 1'b1;
            dly <= rt[i];
            @(posedge CLOCK);
            kick <= 1'b0;
            repeat (100) @(posedge CLOCK);
            rd(OFS_ERR_FLAGS, i ? 32'h10 : 32'h0);
        end
        apb(1'b1, OFS_ERR_FLAGS, 32'h10);
        for (int i = 0; i < 5; i++)
        begin
            lfsr = lfsr_next(lfsr);
            sq[i] = lfsr[5:0];
            {XFER_EP, XFER_TX, XFER_ODD} <= sq[i];
            pulse(13'h1000);
        end
        for (int i = 0; i < 4; i++)
        begin
            rd(OFS_TOKEN_DONE, 32'h08);
            rd(OFS_XFER_STATUS, {24'h0, sq[i], 2'b00});
            apb(1'b1, OFS_TOKEN_DONE, 32'h08);
        end
        rd(OFS_TOKEN_DONE, 32'h0);
        LINE_J <= 1'b1;
        LINE_SE0 <= 1'b1;
        apb(1'b1, OFS_LINK_CONTROL, 32'h01);
        pulse(13'h100);
        #1 cmp(32'({MODULE_ENABLE, PACKET_DISABLE}), 32'h3);
        rd(OFS_LINK_CONTROL, 32'hE1);
        TOKEN_BUSY <= 1'b1;
        apb(1'b1, OFS_LINK_CONTROL, 32'h1D);
        #1 cmp(32'({BUS_RESET_DRIVE, FRAME_START_ENABLE, RESUME_DRIVE, MODULE_ENABLE, PACKET_DISABLE}), 32'h1C);
        rd(OFS_LINK_CONTROL, 32'hFD);
        n = 0;
        while (SOF_SEND !== 1'b1 && n < TICKS + 5)
        begin
            @(negedge CLOCK);
            n++;
        end
        cmp(32'(SOF_SEND), 32'h1);
        if (SOF_SEND !== 1'b1)
            end_of_test();
        pulse(13'hC00);
        rd(OFS_ERR_FLAGS, 32'h02);
        repeat (25 * TICKS) @(posedge CLOCK);
        apb(1'b1, OFS_LINK_CONTROL, 32'h09);
        #1 cmp(32'({LS_EOP_APPEND, BUS_RESET_DRIVE}), 32'h2);
        apb(1'b1, OFS_LINK_CONTROL, 32'h0B);
        #1 cmp(32'(PINGPONG_RESET), 32'h1);
        apb(1'b1, OFS_LINK_CONTROL, 32'h00);
        #1 cmp(32'(HOST_LOGIC_RESET), 32'h1);
        lfsr = lfsr_next(lfsr);
        apb(1'b1, OFS_FUNC_ADDRESS, {24'h0, lfsr});
        #1 cmp(32'({LOW_SPEED_NEXT, FUNC_ADDRESS}), {24'h0, lfsr});
        rd(OFS_FUNC_ADDRESS, {24'h0, lfsr});
        FRAME_NUMBER <= 11'h5A3;
        pulse(13'h200);
        rd(OFS_FRAME_LOW, 32'hA3);
        repeat (2) @(posedge CLOCK);
        end_of_test();
    end
endmodule
